// File: design/udi_pkg.sv
// Purpose: Shared constants and carrier types for the DMA interrupt status bank
// Assumes: APB register access, 32-bit data, full byte addresses
// Notes: Endpoints 0 and 1 are control endpoints without DMA
package udi_pkg;

   localparam logic [31:0] SUMMARY_ADDR = 32'he010_c290;
   localparam logic [31:0] ENABLE_ADDR = 32'he010_c294;
   localparam logic [31:0] EOT_STATUS_ADDR = 32'he010_c2a0;
   localparam logic [31:0] EOT_CLEAR_ADDR = 32'he010_c2a4;
   localparam logic [31:0] EOT_SET_ADDR = 32'he010_c2a8;
   localparam logic [31:0] REQ_STATUS_ADDR = 32'he010_c2ac;
   localparam logic [31:0] REQ_CLEAR_ADDR = 32'he010_c2b0;
   localparam logic [31:0] REQ_SET_ADDR = 32'he010_c2b4;
   localparam logic [31:0] ERR_STATUS_ADDR = 32'he010_c2b8;
   localparam logic [31:0] ERR_CLEAR_ADDR = 32'he010_c2bc;
   localparam logic [31:0] ERR_SET_ADDR = 32'he010_c2c0;

   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [2:0] ENABLE_RESET = 3'h0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   // Endpoints that may be raised by the DMA engine
   localparam logic [31:0] DMA_EP_MASK = 32'hffff_fffc;

   localparam int EOT_BIT = 0;
   localparam int REQ_BIT = 1;
   localparam int ERR_BIT = 2;
   localparam int ENABLE_WIDTH = 3;

   typedef enum logic [1:0] {
      UDI_DD_NONE = 2'b00,
      UDI_DD_RETIRED = 2'b01,
      UDI_DD_ERROR = 2'b10
   } udi_dd_reason_type;

   // Events from the DMA engine, one of each kind per cycle
   typedef struct packed {
      logic eot_valid;
      logic eot_error;
      logic [4:0] eot_ep;
      logic req_valid;
      logic req_desc_valid;
      logic [4:0] req_ep;
      logic err_valid;
      logic [4:0] err_ep;
   } udi_event_type;

   // Descriptor status field update toward the DMA engine
   typedef struct packed {
      logic write;
      logic [4:0] ep;
      udi_dd_reason_type reason;
   } udi_desc_status_type;

endpackage

// File: design/udi_status_bank.sv
// Purpose: One 32-bit sticky status bank with set and clear strobes
// Assumes: Set strobes and clear strobe come in the same cycle at most
// Notes: Any set beats a clear of the same bit
`timescale 1ns/1ps
module udi_status_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [31:0] hw_set,
   input wire logic [31:0] sw_set,
   input wire logic [31:0] sw_clear,
   output logic [31:0] status
);

   logic [31:0] status_reg;
   logic [31:0] status_next;

   always_comb begin
      status_next = (status_reg & ~sw_clear) | sw_set | hw_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= udi_pkg::STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   assign status = status_reg;

   set_wins_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (hw_set != 32'h0000_0000) |=> ((status & $past(hw_set)) == $past(hw_set)))
      else $error("hardware set lost against clear");

   clear_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sw_clear != 32'h0000_0000) |=>
      ((status & $past(sw_clear & ~hw_set & ~sw_set)) == 32'h0000_0000))
      else $error("cleared bit still set");

   zero_no_change_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ((status ^ $past(status)) & ~$past(hw_set | sw_set | sw_clear)) == 32'h0)
      else $error("bit changed without cause");

endmodule

// File: design/udi_dma_irq.sv
// Purpose: DMA interrupt status banks, summary and enable with APB access
// Assumes: Zero-wait APB slave; DMA engine events synchronous to pclk
// Notes: Read data is captured in the setup cycle
// Functional notes
// - Enable bit 1 gates request summary
// - Enable bit 2 gates error summary
// - Transfer done sets endpoint end bit
// - Completion reason written to descriptor status
// - End status read-only, zero reset
// - End clear write ones clears bits
// - End set write ones sets bits
// - Request without valid descriptor sets bit
// - Request status read-only, zero reset
// - Request clear write ones clears bits
// - Request set write ones sets bits
// - Bus error response sets error bit
// - Error status read-only, zero reset
// - Summary bits OR each status bank
// - Enable bit 0 gates end summary
// - Interrupt is OR of enabled summaries
// - Error clear write ones clears bits
`timescale 1ns/1ps
module udi_dma_irq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire udi_pkg::udi_event_type dma_event,
   output udi_pkg::udi_desc_status_type desc_status,
   output logic dma_irq
);

   logic [31:0] prdata_reg;
   logic [31:0] read_value;
   logic [2:0] enable_reg;
   logic [2:0] summary;
   logic [31:0] eot_status;
   logic [31:0] req_status;
   logic [31:0] err_status;
   logic [31:0] eot_hw;
   logic [31:0] req_hw;
   logic [31:0] err_hw;
   logic [31:0] eot_set;
   logic [31:0] eot_clear;
   logic [31:0] req_set;
   logic [31:0] req_clear;
   logic [31:0] err_set;
   logic [31:0] err_clear;
   logic write_access;
   logic mapped;
   udi_pkg::udi_desc_status_type desc_status_reg;

   // One-hot endpoint bit, control endpoints masked off
   function automatic logic [31:0] ep_bit(input logic valid, input logic [4:0] ep);
      logic [31:0] onehot;
      onehot = 32'h0000_0001 << ep;
      ep_bit = valid ? (onehot & udi_pkg::DMA_EP_MASK) : 32'h0000_0000;
   endfunction

   // Write strobes for one register, all zero when not addressed
   function automatic logic [31:0] wr_bits(input logic wr, input logic [31:0] addr,
         input logic [31:0] target, input logic [31:0] data);
      wr_bits = (wr && (addr == target)) ? data : 32'h0000_0000;
   endfunction

   function automatic logic is_mapped(input logic [31:0] addr);
      case (addr)
         udi_pkg::SUMMARY_ADDR, udi_pkg::ENABLE_ADDR,
         udi_pkg::EOT_STATUS_ADDR, udi_pkg::EOT_CLEAR_ADDR, udi_pkg::EOT_SET_ADDR,
         udi_pkg::REQ_STATUS_ADDR, udi_pkg::REQ_CLEAR_ADDR, udi_pkg::REQ_SET_ADDR,
         udi_pkg::ERR_STATUS_ADDR, udi_pkg::ERR_CLEAR_ADDR,
         udi_pkg::ERR_SET_ADDR: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   assign write_access = psel && penable && pwrite;
   assign mapped = is_mapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Hardware event decode
   assign eot_hw = ep_bit(dma_event.eot_valid, dma_event.eot_ep);
   assign req_hw = ep_bit(dma_event.req_valid && !dma_event.req_desc_valid,
      dma_event.req_ep);
   assign err_hw = ep_bit(dma_event.err_valid, dma_event.err_ep);

   // Software strobes; status addresses take no write
   assign eot_clear = wr_bits(write_access, paddr, udi_pkg::EOT_CLEAR_ADDR, pwdata);
   assign eot_set = wr_bits(write_access, paddr, udi_pkg::EOT_SET_ADDR, pwdata);
   assign req_clear = wr_bits(write_access, paddr, udi_pkg::REQ_CLEAR_ADDR, pwdata);
   assign req_set = wr_bits(write_access, paddr, udi_pkg::REQ_SET_ADDR, pwdata);
   assign err_clear = wr_bits(write_access, paddr, udi_pkg::ERR_CLEAR_ADDR, pwdata);
   assign err_set = wr_bits(write_access, paddr, udi_pkg::ERR_SET_ADDR, pwdata);

   udi_status_bank eot_bank (
      .pclk(pclk),
      .presetn(presetn),
      .hw_set(eot_hw),
      .sw_set(eot_set),
      .sw_clear(eot_clear),
      .status(eot_status)
   );

   udi_status_bank req_bank (
      .pclk(pclk),
      .presetn(presetn),
      .hw_set(req_hw),
      .sw_set(req_set),
      .sw_clear(req_clear),
      .status(req_status)
   );

   udi_status_bank err_bank (
      .pclk(pclk),
      .presetn(presetn),
      .hw_set(err_hw),
      .sw_set(err_set),
      .sw_clear(err_clear),
      .status(err_status)
   );

   // Only the three defined enable bits are stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= udi_pkg::ENABLE_RESET;
      end else if (write_access && (paddr == udi_pkg::ENABLE_ADDR)) begin
         enable_reg <= pwdata[udi_pkg::ENABLE_WIDTH-1:0];
      end
   end

   assign summary[udi_pkg::EOT_BIT] = |eot_status;
   assign summary[udi_pkg::REQ_BIT] = |req_status;
   assign summary[udi_pkg::ERR_BIT] = |err_status;

   assign dma_irq = |(summary & enable_reg);

   always_comb begin
      case (paddr)
         udi_pkg::SUMMARY_ADDR: read_value = {29'h0, summary};
         udi_pkg::ENABLE_ADDR: read_value = {29'h0, enable_reg};
         udi_pkg::EOT_STATUS_ADDR: read_value = eot_status;
         udi_pkg::REQ_STATUS_ADDR: read_value = req_status;
         udi_pkg::ERR_STATUS_ADDR: read_value = err_status;
         default: read_value = udi_pkg::READ_ZERO;
      endcase
   end

   // Captured in the setup cycle, held through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= udi_pkg::READ_ZERO;
      end else if (psel && !penable && !pwrite) begin
         prdata_reg <= read_value;
      end
   end

   assign prdata = prdata_reg;

   // Descriptor status update, one cycle after the end event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         desc_status_reg <= '{write: 1'b0, ep: 5'h00, reason: udi_pkg::UDI_DD_NONE};
      end else begin
         desc_status_reg.write <= dma_event.eot_valid;
         desc_status_reg.ep <= dma_event.eot_ep;
         desc_status_reg.reason <= !dma_event.eot_valid ? udi_pkg::UDI_DD_NONE :
            (dma_event.eot_error ? udi_pkg::UDI_DD_ERROR : udi_pkg::UDI_DD_RETIRED);
      end
   end

   assign desc_status = desc_status_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   eot_event_sets_a: assert property (
      (dma_event.eot_valid && dma_event.eot_ep > 5'd1) |=> eot_status[$past(dma_event.eot_ep)])
      else $error("end event did not set status bit");

   desc_reason_a: assert property (
      dma_event.eot_valid |=> desc_status.write && desc_status.ep == $past(dma_event.eot_ep)
      && desc_status.reason == ($past(dma_event.eot_error) ? udi_pkg::UDI_DD_ERROR
      : udi_pkg::UDI_DD_RETIRED))
      else $error("descriptor status update wrong");

   desc_quiet_a: assert property (
      !dma_event.eot_valid |=> !desc_status.write)
      else $error("descriptor status written without event");

   eot_status_ro_a: assert property (
      (write_access && paddr == udi_pkg::EOT_STATUS_ADDR && eot_hw == 32'h0)
      |=> eot_status == $past(eot_status))
      else $error("end status changed by a write");

   eot_set_reg_a: assert property (
      (write_access && paddr == udi_pkg::EOT_SET_ADDR)
      |=> (eot_status & $past(pwdata)) == $past(pwdata))
      else $error("end set write did not set bits");

   req_event_sets_a: assert property (
      (dma_event.req_valid && !dma_event.req_desc_valid && dma_event.req_ep > 5'd1)
      |=> req_status[$past(dma_event.req_ep)])
      else $error("descriptor request not flagged");

   req_clear_reg_a: assert property (
      (write_access && paddr == udi_pkg::REQ_CLEAR_ADDR && req_hw == 32'h0)
      |=> (req_status & $past(pwdata)) == 32'h0)
      else $error("request clear write left bits set");

   err_event_sets_a: assert property (
      (dma_event.err_valid && dma_event.err_ep > 5'd1) |=> err_status[$past(dma_event.err_ep)])
      else $error("bus error not flagged");

   err_clear_reg_a: assert property (
      (write_access && paddr == udi_pkg::ERR_CLEAR_ADDR && err_hw == 32'h0)
      |=> (err_status & $past(pwdata)) == 32'h0)
      else $error("error clear write left bits set");

   ctrl_ep_quiet_a: assert property (
      $rose(eot_status[0]) |-> $past(write_access && paddr == udi_pkg::EOT_SET_ADDR))
      else $error("control endpoint bit set by hardware");

   summary_or_a: assert property (
      summary == {|err_status, |req_status, |eot_status})
      else $error("summary does not match status banks");

   irq_gate_a: assert property (
      (eot_status != 32'h0 && enable_reg[0]) |-> dma_irq)
      else $error("enabled end summary gave no interrupt");

   irq_blocked_a: assert property (
      (enable_reg == 3'b000) |-> !dma_irq)
      else $error("interrupt with all enables low");

   enable_write_a: assert property (
      (write_access && paddr == udi_pkg::ENABLE_ADDR)
      |=> enable_reg == $past(pwdata[2:0]) ##1 enable_reg == $past(enable_reg))
      else $error("enable register write lost");

   read_back_a: assert property (
      (psel && !penable && !pwrite) ##1 (psel && penable) |-> prdata == $past(read_value))
      else $error("read data not held from setup");

   unmapped_err_a: assert property (
      (psel && penable && !is_mapped(paddr)) |-> pslverr)
      else $error("unmapped access not flagged");

   eot_clear_reg_a: assert property (
      (write_access && paddr == udi_pkg::EOT_CLEAR_ADDR && eot_hw == 32'h0)
      |=> (eot_status & $past(pwdata)) == 32'h0)
      else $error("end clear write left bits set");

   req_set_reg_a: assert property (
      (write_access && paddr == udi_pkg::REQ_SET_ADDR)
      |=> (req_status & $past(pwdata)) == $past(pwdata))
      else $error("request set write did not set bits");

   req_status_ro_a: assert property (
      (write_access && paddr == udi_pkg::REQ_STATUS_ADDR && req_hw == 32'h0)
      |=> req_status == $past(req_status))
      else $error("request status changed by a write");

   err_status_ro_a: assert property (
      (write_access && paddr == udi_pkg::ERR_STATUS_ADDR && err_hw == 32'h0)
      |=> err_status == $past(err_status))
      else $error("error status changed by a write");

   req_irq_gate_a: assert property (
      (req_status != 32'h0 && enable_reg[1]) |-> dma_irq)
      else $error("enabled request summary gave no interrupt");

   err_irq_gate_a: assert property (
      (err_status != 32'h0 && enable_reg[2]) |-> dma_irq)
      else $error("enabled error summary gave no interrupt");

   irq_cause_a: assert property (
      dma_irq |-> ((eot_status != 32'h0 && enable_reg[0])
      || (req_status != 32'h0 && enable_reg[1])
      || (err_status != 32'h0 && enable_reg[2])))
      else $error("interrupt without an enabled summary");

   ctrl_req_quiet_a: assert property (
      $rose(req_status[1]) |-> $past(write_access && paddr == udi_pkg::REQ_SET_ADDR))
      else $error("control endpoint request bit set by hardware");

   ctrl_err_quiet_a: assert property (
      $rose(err_status[0]) |-> $past(write_access && paddr == udi_pkg::ERR_SET_ADDR))
      else $error("control endpoint error bit set by hardware");

   eot_irq_c: cover property (dma_event.eot_valid && enable_reg[0] ##1 dma_irq);
   err_irq_c: cover property (err_status != 32'h0 && enable_reg[2] ##1 dma_irq);
   collide_c: cover property (eot_hw != 32'h0 && (eot_clear & eot_hw) != 32'h0);
   req_flag_c: cover property (req_hw != 32'h0 ##1 summary[1]);
   unmapped_c: cover property (pslverr);

endmodule

// File: testbench/udi_dma_model.sv
// Purpose: DMA engine stand-in raising events and watching descriptor updates
// Assumes: Events are one-cycle pulses launched just after a rising edge
// Notes: Drives nothing unless a scenario calls fire
`timescale 1ns/1ps
module udi_dma_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire udi_pkg::udi_desc_status_type desc_status,
   output udi_pkg::udi_event_type dma_event
);
   udi_pkg::udi_desc_status_type last_desc;
   initial begin
      dma_event <= '0;
      last_desc <= '0;
   end
   // Keep the latest descriptor status update
   always @(posedge pclk) begin
      if (presetn && desc_status.write === 1'b1) begin
         last_desc <= desc_status;
      end
   end
   // Kind 0 end of transfer, 1 descriptor request, 2 bus error
   task automatic fire(input int kind, input logic [4:0] ep, input logic flag);
      udi_pkg::udi_event_type ev;
      ev = '0;
      ev.eot_valid = (kind == 0);
      ev.eot_error = flag;
      ev.eot_ep = ep;
      ev.req_valid = (kind == 1);
      ev.req_desc_valid = flag;
      ev.req_ep = ep;
      ev.err_valid = (kind == 2);
      ev.err_ep = ep;
      @(posedge pclk);
      dma_event <= ev;
      @(posedge pclk);
      dma_event <= '0;
   endtask
endmodule

// File: testbench/usb_dma_irq_status_bank_tb_top.sv
// Purpose: Self-checking bench for the DMA interrupt status banks
// Assumes: APB master waits on pready; events come from the model
// Notes: Each scenario is its own task
`timescale 1ns/1ps
`define CHK(g, e, m) cmp_word(32'(g), 32'(e), m)
module usb_dma_irq_status_bank_tb_top;
   localparam logic [31:0] ST_A[3] = '{udi_pkg::EOT_STATUS_ADDR, udi_pkg::REQ_STATUS_ADDR,
      udi_pkg::ERR_STATUS_ADDR};
   localparam logic [31:0] SET_A[3] = '{udi_pkg::EOT_SET_ADDR, udi_pkg::REQ_SET_ADDR,
      udi_pkg::ERR_SET_ADDR};
   localparam logic [31:0] CLR_A[3] = '{udi_pkg::EOT_CLEAR_ADDR, udi_pkg::REQ_CLEAR_ADDR,
      udi_pkg::ERR_CLEAR_ADDR};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0000_0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic dma_irq;
   udi_pkg::udi_event_type dma_event;
   udi_pkg::udi_desc_status_type desc_status;
   int err_total = 0;
   int checks_done = 0;
   udi_dma_irq udi_dma_irq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dma_event(dma_event),
      .desc_status(desc_status), .dma_irq(dma_irq));
   udi_dma_model udi_dma_model_inst (.pclk(pclk), .presetn(presetn),
      .desc_status(desc_status), .dma_event(dma_event));
   always #2.5 pclk = ~pclk;
   task automatic report_and_stop();
      $display("checks %0d, errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: %s got %h", $time, m, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      `CHK(e, 1'b0, "write error");
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] x, input string m);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x, m);
   endtask
   task automatic t_reset();
      rd(udi_pkg::ENABLE_ADDR, 32'h0000_0000, "enable reset");
      rd(udi_pkg::EOT_STATUS_ADDR, 32'h0000_0000, "end reset");
      rd(udi_pkg::REQ_STATUS_ADDR, 32'h0000_0000, "req reset");
      rd(udi_pkg::ERR_STATUS_ADDR, 32'h0000_0000, "err reset");
      rd(udi_pkg::SUMMARY_ADDR, 32'h0000_0000, "summary reset");
      `CHK(dma_irq, 1'b0, "irq reset");
   endtask
   task automatic t_set_clear();
      for (int k = 0; k < 3; k++) begin
         wr(ST_A[k], 32'hffff_ffff);
         rd(ST_A[k], 32'h0000_0000, "status written");
         wr(SET_A[k], 32'ha5a5_0003);
         rd(SET_A[k], 32'h0000_0000, "set read");
         rd(ST_A[k], 32'ha5a5_0003, "set bits");
         wr(CLR_A[k], 32'h0000_0f01);
         rd(ST_A[k], 32'ha5a5_0002, "clear bits");
         wr(CLR_A[k], 32'hffff_ffff);
         rd(ST_A[k], 32'h0000_0000, "clear all");
      end
   endtask
   task automatic t_events();
      udi_dma_model_inst.fire(0, 5'd5, 1'b1);
      rd(udi_pkg::EOT_STATUS_ADDR, 32'h0000_0020, "end event");
      `CHK(udi_dma_model_inst.last_desc, {1'b1, 5'd5, udi_pkg::UDI_DD_ERROR}, "reason");
      udi_dma_model_inst.fire(0, 5'd6, 1'b0);
      rd(udi_pkg::EOT_STATUS_ADDR, 32'h0000_0060, "end event 2");
      `CHK(udi_dma_model_inst.last_desc, {1'b1, 5'd6, udi_pkg::UDI_DD_RETIRED}, "ok");
      udi_dma_model_inst.fire(1, 5'd8, 1'b1);
      udi_dma_model_inst.fire(1, 5'd9, 1'b0);
      rd(udi_pkg::REQ_STATUS_ADDR, 32'h0000_0200, "req event");
      udi_dma_model_inst.fire(2, 5'd31, 1'b0);
      rd(udi_pkg::ERR_STATUS_ADDR, 32'h8000_0000, "err event");
      udi_dma_model_inst.fire(0, 5'd1, 1'b0);
      udi_dma_model_inst.fire(1, 5'd0, 1'b0);
      udi_dma_model_inst.fire(2, 5'd1, 1'b0);
      rd(udi_pkg::EOT_STATUS_ADDR, 32'h0000_0060, "ctrl end");
      rd(udi_pkg::REQ_STATUS_ADDR, 32'h0000_0200, "ctrl req");
      rd(udi_pkg::ERR_STATUS_ADDR, 32'h8000_0000, "ctrl err");
      wr(udi_pkg::ERR_CLEAR_ADDR, 32'hffff_ffff);
      rd(udi_pkg::ERR_STATUS_ADDR, 32'h0000_0000, "err clear");
      wr(udi_pkg::EOT_CLEAR_ADDR, 32'hffff_ffff);
      wr(udi_pkg::REQ_CLEAR_ADDR, 32'hffff_ffff);
   endtask
   task automatic t_irq();
      for (int k = 0; k < 3; k++) begin
         wr(SET_A[k], 32'h0000_0004);
         rd(udi_pkg::SUMMARY_ADDR, 32'(1 << k), "summary");
         wr(udi_pkg::ENABLE_ADDR, 32'(~(1 << k) & 7));
         @(negedge pclk);
         `CHK(dma_irq, 1'b0, "irq masked");
         wr(udi_pkg::ENABLE_ADDR, 32'(1 << k));
         rd(udi_pkg::ENABLE_ADDR, 32'(1 << k), "enable back");
         `CHK(dma_irq, 1'b1, "irq raised");
         wr(CLR_A[k], 32'h0000_0004);
         @(negedge pclk);
         `CHK(dma_irq, 1'b0, "irq cleared");
      end
   endtask
   task automatic t_collide();
      logic [31:0] r;
      logic e;
      wr(udi_pkg::EOT_SET_ADDR, 32'h0000_0010);
      fork
         wr(udi_pkg::EOT_CLEAR_ADDR, 32'h0000_0030);
         begin
            @(posedge pclk);
            udi_dma_model_inst.fire(0, 5'd5, 1'b0);
         end
      join
      rd(udi_pkg::EOT_STATUS_ADDR, 32'h0000_0020, "set beats clear");
      apb(1'b0, 32'he010_c298, 32'h0000_0000, r, e);
      `CHK(e, 1'b1, "unmapped error");
      `CHK(r, 32'h0000_0000, "unmapped data");
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_set_clear();
      t_events();
      t_irq();
      t_collide();
      report_and_stop();
   end
endmodule
